/* File: sar_adc_cell_model.sv */
/* Behavioural analog cell answering one raw value per selected channel.
   Assumes the control block samples the value after its sample phase. */
`timescale 1ns/1ps
module sar_adc_cell_model (
  input  wire        sample_active,
  input  wire [2:0]  channel_select,
  output logic [9:0] analog_result
);
  // Settled value per channel; inverted while the input still tracks.
  // one channel routed
  always_comb begin
    analog_result = 10'h155 + {7'h00, channel_select} * 10'h041;
    if (sample_active) analog_result = ~analog_result;
  end
endmodule // sar_adc_cell_model

/* File: sar_adc_consts.vh */
/*
 * Constants for the successive-approximation converter control block:
 * register byte offsets, field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design and bench files; definitions only.
 */
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH

// Register byte offsets on the 32-bit bus.
`define OFS_CONTROL         8'h00
`define OFS_MODE            8'h04
`define OFS_CHAN_ENABLE     8'h10
`define OFS_CHAN_DISABLE    8'h14
`define OFS_CHAN_STATUS     8'h18
`define OFS_STATUS          8'h1C
`define OFS_LAST_RESULT     8'h20
`define OFS_INT_ENABLE      8'h24
`define OFS_INT_DISABLE     8'h28
`define OFS_INT_MASK        8'h2C
`define OFS_CHAN_RESULT0    8'h30
`define OFS_CHAN_RESULT7    8'h4C

// Control register bits.
`define CTL_SOFT_RESET      0
`define CTL_START           1

// Mode register fields.
`define MODE_TRIG_EN        0
`define MODE_TRIG_SEL_LO    1
`define MODE_TRIG_SEL_HI    3
`define MODE_LOW_RES        4
`define MODE_SLEEP          5
`define MODE_DIV_LO         8
`define MODE_DIV_HI         13
`define MODE_STARTUP_LO     16
`define MODE_STARTUP_HI     22
`define MODE_SHOLD_LO       24
`define MODE_SHOLD_HI       27
`define MODE_RESET          32'h00000000
`define MODE_WRITE_MASK     32'h0F7F3F3F

// Trigger source codes.
`define TRIG_TIMER0         3'h0
`define TRIG_TIMER1         3'h1
`define TRIG_TIMER2         3'h2
`define TRIG_EXTERNAL       3'h6

// Status register bit positions.
`define ST_EOC_LO           0
`define ST_OVR_LO           8
`define ST_RESULT_READY_FLAG             16
`define ST_GOVR             17

// Timing: data cycles per conversion in converter clocks.
`define CONV_DATA_CLOCKS    4'hA
`define CLOCK_PERIOD_NS     10

`endif

/* File: sar_adc_conversion_control_tb_top.sv */
/* Self-checking bench for the converter control block.
   It is the only AHB-Lite master; the cell model answers results. */
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module sar_adc_conversion_control_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic        external_trigger_input = 1'b0;
  logic [2:0]  timer_waveform_output = 3'h0;
  logic        rd_dp = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire  [9:0]  analog_result;
  wire  [2:0]  channel_select;
  wire         sample_active;
  wire         convert_active;
  wire         converter_irq;
  wire         dma_size_16;
  wire  [7:0]  pin_to_converter;
  wire         dma_request;
  logic [31:0] exp_v;
  int          n_dma = 0;
  logic [31:0] exp_q[$];
  logic [9:0]  r;
  logic [5:0]  div;
  int          n_errors = 0;
  int          tests_run = 0;
  // Free-running bus clock.
  always #5 hclk = ~hclk;
  sar_adc_ctrl sar_adc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .external_trigger_input(external_trigger_input),
    .timer_waveform_output(timer_waveform_output), .analog_result(analog_result),
    .channel_select(channel_select), .pin_to_converter(pin_to_converter), .sample_active(sample_active),
    .convert_active(convert_active), .converter_clock(), .converter_irq(converter_irq),
    .dma_request(dma_request), .dma_size_16(dma_size_16));
  sar_adc_cell_model sar_adc_cell_model_inst (.sample_active(sample_active),
    .channel_select(channel_select), .analog_result(analog_result));
  function automatic logic [9:0] raw(input logic [2:0] c);
    return 10'h155 + {7'h00, c} * 10'h041;
  endfunction
  task automatic conclude;
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hw;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    hsel <= 1'b1;
    hw();
    htrans <= 2'h0;
    hwdata <= d;
    hw();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    haddr <= {24'h000000, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    hsel <= 1'b1;
    hw();
    htrans <= 2'h0;
    rd_dp <= 1'b1;
    exp_q.push_back(e);
    hw();
    rd_dp <= 1'b0;
  endtask
  task automatic trig(input int s);
    if (s == 6) external_trigger_input <= 1'b1;
    else timer_waveform_output[s] <= 1'b1;
    repeat (2) @(posedge hclk);
    external_trigger_input <= 1'b0;
    timer_waveform_output <= 3'h0;
  endtask
  task automatic idle;
    int n;
    int k;
    n = 0;
    k = 0;
    while (sample_active !== 1'b1 && convert_active !== 1'b1 && n < 300) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 300) n_errors++;
    n = 0;
    while (k < 8 && n < 4000) begin
      @(negedge hclk);
      n++;
      k = (sample_active || convert_active) ? 0 : k + 1;
    end
    if (k < 8) n_errors++;
    if (n_errors > 0) conclude();
    @(posedge hclk);
  endtask
  task automatic quiet;
    repeat (6) @(negedge hclk);
    `CHK(sample_active || convert_active, 1'b0)
    @(posedge hclk);
  endtask
  // Compares each read against the oldest noted value, taken off the queue once.
  always @(posedge hclk) begin
    if (rd_dp && hreadyout && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK(hrdata, exp_v)
    end
  end
  // Counts transfer request pulses, one per rise of the ready flag.
  always @(posedge hclk) begin
    if (dma_request === 1'b1) n_dma++;
  end
  initial begin
    void'($urandom(81));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`OFS_MODE, 32'h00000000);
    rd(`OFS_STATUS, 32'h00000000);
    rd(`OFS_CHAN_STATUS, 32'h00000000);
    rd(8'h50, 32'h00000000);
    `CHK(pin_to_converter, 8'h00)
    div = 6'($urandom % 4);
    wr(`OFS_MODE, {18'h00000, div, 8'h00});
    wr(`OFS_INT_ENABLE, 32'h00010000);
    wr(`OFS_CHAN_ENABLE, 32'h0000000A);
    rd(`OFS_CHAN_STATUS, 32'h0000000A);
    `CHK(pin_to_converter, 8'h0A)
    wr(`OFS_CONTROL, 32'h00000002);
    idle();
    @(negedge hclk);
    `CHK(converter_irq, 1'b1)
    `CHK(n_dma, 1)
    @(posedge hclk);
    rd(`OFS_INT_MASK, 32'h00010000);
    rd(`OFS_STATUS, 32'h0003000A);
    rd(`OFS_CHAN_RESULT0 + 8'h04, {22'h0, raw(3'h1)});
    rd(`OFS_CHAN_RESULT0 + 8'h0C, {22'h0, raw(3'h3)});
    rd(`OFS_STATUS, 32'h00010000);
    rd(`OFS_LAST_RESULT, {22'h0, raw(3'h3)});
    rd(`OFS_STATUS, 32'h00000000);
    @(negedge hclk);
    `CHK(converter_irq, 1'b0)
    @(posedge hclk);
    // channel set changed only while idle
    wr(`OFS_CHAN_DISABLE, 32'h00000008);
    wr(`OFS_MODE, 32'h0000001D);
    timer_waveform_output <= 3'($urandom);
    quiet();
    timer_waveform_output <= 3'h0;
    `CHK(dma_size_16, 1'b0)
    trig(6);
    idle();
    trig(6);
    idle();
    r = raw(3'h1);
    rd(`OFS_STATUS, 32'h00030202);
    rd(`OFS_CHAN_RESULT0 + 8'h04, {24'h0, r[9:2]});
    rd(`OFS_LAST_RESULT, {24'h0, r[9:2]});
    rd(`OFS_STATUS, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_MODE, 32'((i == 3 ? 6 : i) * 2 + 1));
      trig(i == 3 ? 6 : i);
      idle();
      rd(`OFS_LAST_RESULT, {22'h0, raw(3'h1)});
    end
    wr(`OFS_CONTROL, 32'h00000002);
    trig(6);
    idle();
    rd(`OFS_STATUS, 32'h00010002);
    rd(`OFS_LAST_RESULT, {22'h0, raw(3'h1)});
    wr(`OFS_MODE, 32'h0000000C);
    trig(6);
    quiet();
    // Control bit zero resets the configuration, sequencer, result and flag registers and converter_clock,
    // but not channel_select, phase_count, trig_prev, the bus registers or the other output registers.
    wr(`OFS_CONTROL, 32'h00000001);
    rd(`OFS_MODE, 32'h00000000);
    rd(`OFS_INT_MASK, 32'h00000000);
    rd(`OFS_CHAN_STATUS, 32'h00000000);
    `CHK(pin_to_converter, 8'h00)
    @(posedge hclk);
    conclude();
  end
endmodule // sar_adc_conversion_control_tb_top
bind sar_adc_ctrl sar_adc_ctrl_checker sar_adc_ctrl_checker_inst (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .channel_select(channel_select), .sample_active(sample_active),
  .convert_active(convert_active), .converter_clock(converter_clock), .converter_irq(converter_irq),
  .dma_request(dma_request), .dma_size_16(dma_size_16));

/* File: sar_adc_ctrl.v */
/*
 * Conversion control for an eight-channel successive-approximation converter
 * with an AHB-Lite register slave, trigger logic, sequencer, converter clock
 * prescaler, result registers, flags, interrupt line and DMA request.
 * Assumes a single hclk domain, trigger and timer inputs synchronous to hclk,
 * and an analog cell that presents its result on analog_result when asked.
 */
`timescale 1ns/1ps
`include "sar_adc_consts.vh"

// Functional notes
// R1: One of eight inputs is routed to the converter at a time.
// R2: Eight or ten bit results; ten bits after reset.
// R3: Start by software, external rising edge or timer output.
// R4: Conversion takes sample-hold clocks then ten converter clocks.
// R5: Converter clock ranges from master clock over 2 to over 128.
// R6: Low resolution results sit in eight low bits, upper bits zero.
// R7: DMA transfer size is 16 bits, or 8 bits in low resolution.
// R8: Result goes to channel register and last-result register.
// R9: Completion sets channel flag and ready flag; ready rising requests DMA.
// R10: Enabled end and ready flags drive the interrupt line.
// R11: Reading a channel result clears its end flag.
// R12: Reading last result clears ready flag and last channel end flag.
// R13: Unread channel result overwritten sets the channel overrun flag.
// R14: Completion while ready flag set sets the general overrun flag.
// R15: Reading status clears all overrun flags.
// R16: Software must not disable a channel during its conversion.
// R17: Enabling a channel hands its pin to the converter.
// R18: One start converts every enabled channel, then waits.
// R19: Hardware trigger honoured only while trigger enable is set.
// R20: Software start works even with hardware trigger enabled.
// R21: Triggers during a running sequence are ignored.
// R22: Converter clock period is master period times two times field plus one.
// R23: Channels are converted in ascending order.
module sar_adc_ctrl (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        external_trigger_input,
  input  wire [2:0]  timer_waveform_output,
  input  wire [9:0]  analog_result,
  output reg  [2:0]  channel_select,
  output reg  [7:0]  pin_to_converter,
  output reg         sample_active,
  output reg         convert_active,
  output reg         converter_clock,
  output reg         converter_irq,
  output reg         dma_request,
  output reg         dma_size_16
);

  localparam ST_IDLE   = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONV   = 2'h2;

  reg  [31:0] mode;
  reg  [7:0]  chan_enabled;
  reg  [7:0]  eoc;
  reg  [7:0]  overrun;
  reg         result_ready_flag;
  reg         general_overrun_flag;
  reg  [17:0] irq_mask;
  reg  [9:0]  chan_data [0:7];
  reg  [9:0]  last_result_field;
  reg  [2:0]  last_chan;
  reg  [1:0]  state;
  reg  [5:0]  div_count;
  reg  [4:0]  phase_count;
  reg  [7:0]  pending;
  reg         trig_prev;
  reg         ap_valid;
  reg         ap_write;
  reg  [7:0]  ap_addr;
  reg         ready_prev;

  wire        hardware_trigger_enable       = mode[`MODE_TRIG_EN];
  wire [2:0]  trigger_source_select         = mode[`MODE_TRIG_SEL_HI:`MODE_TRIG_SEL_LO];
  wire        low_resolution_select         = mode[`MODE_LOW_RES];
  wire [5:0]  converter_clock_divider_field = mode[`MODE_DIV_HI:`MODE_DIV_LO];
  wire [3:0]  sample_hold_time_field        = mode[`MODE_SHOLD_HI:`MODE_SHOLD_LO];

  // Lowest set bit index of a channel vector.
  function [2:0] lowest_chan;
    input [7:0] v;
    integer i;
    begin
      lowest_chan = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (v[i]) begin
          lowest_chan = i[2:0];
        end
      end
    end
  endfunction

  // Result as stored, truncated in low resolution.
  function [9:0] shape_result;
    input [9:0] raw;
    input       low;
    begin
      shape_result = low ? {2'h0, raw[9:2]} : raw;
    end
  endfunction

  // Trigger source chosen by the select field.
  reg trig_level;
  always @* begin
    case (trigger_source_select)
      `TRIG_TIMER0:   trig_level = timer_waveform_output[0];
      `TRIG_TIMER1:   trig_level = timer_waveform_output[1];
      `TRIG_TIMER2:   trig_level = timer_waveform_output[2];
      `TRIG_EXTERNAL: trig_level = external_trigger_input;
      default:        trig_level = 1'b0;
    endcase
  end

  // Bus decode for the data phase.
  wire        addr_take   = hsel & hready & htrans[1];
  wire        wr_now      = ap_valid & ap_write;
  wire        rd_now      = ap_valid & ~ap_write;
  wire        soft_reset  = wr_now & (ap_addr == `OFS_CONTROL) & hwdata[`CTL_SOFT_RESET];
  wire        rd_status   = rd_now & (ap_addr == `OFS_STATUS);
  wire        rd_last     = rd_now & (ap_addr == `OFS_LAST_RESULT);
  wire        rd_chan     = rd_now & (ap_addr >= `OFS_CHAN_RESULT0) & (ap_addr <= `OFS_CHAN_RESULT7);
  wire [2:0]  rd_chan_idx = ap_addr[4:2] - 3'h4;
  // R20: software start not gated by the trigger enable.
  wire        sw_start    = wr_now & (ap_addr == `OFS_CONTROL) & hwdata[`CTL_START];
  // R3: rising edge of selected hardware trigger.
  wire        hw_edge     = trig_level & ~trig_prev;
  // R19: hardware trigger gated by enable.
  wire        start_req   = sw_start | (hardware_trigger_enable & hw_edge);
  // R22: converter clock tick every field plus one master cycles per half.
  wire        half_tick   = (div_count == converter_clock_divider_field);
  wire        conv_edge   = half_tick & converter_clock;
  wire [17:0] flags       = {1'b0, result_ready_flag, 8'h00, eoc};
  wire [3:0]  sample_last = sample_hold_time_field;

  // Address phase capture; the slave never inserts waits.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ap_valid  <= addr_take;
      ap_write  <= hwrite;
      ap_addr   <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data mux registered one cycle ahead; unmapped reads return zero.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_take & ~hwrite) begin
      case (haddr[7:0])
        `OFS_MODE:        hrdata <= mode;
        `OFS_CHAN_STATUS: hrdata <= {24'h0, chan_enabled};
        `OFS_STATUS:      hrdata <= {14'h0, general_overrun_flag, result_ready_flag, overrun, eoc};
        `OFS_LAST_RESULT: hrdata <= {22'h0, last_result_field};
        `OFS_INT_MASK:    hrdata <= {14'h0, irq_mask};
        default: begin
          if (haddr[7:0] >= `OFS_CHAN_RESULT0 && haddr[7:0] <= `OFS_CHAN_RESULT7) begin
            hrdata <= {22'h0, chan_data[haddr[4:2] - 3'h4]};
          end else begin
            hrdata <= 32'h00000000;
          end
        end
      endcase
    end
  end

  // Configuration registers written by software.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode         <= `MODE_RESET;
      chan_enabled <= 8'h00;
      irq_mask     <= 18'h00000;
    end else if (soft_reset) begin
      mode         <= `MODE_RESET;
      chan_enabled <= 8'h00;
      irq_mask     <= 18'h00000;
    end else if (wr_now) begin
      case (ap_addr)
        // R2: resolution bit held in mode, clear after reset.
        `OFS_MODE:         mode <= hwdata & `MODE_WRITE_MASK;
        `OFS_CHAN_ENABLE:  chan_enabled <= chan_enabled | hwdata[7:0];
        `OFS_CHAN_DISABLE: chan_enabled <= chan_enabled & ~hwdata[7:0];
        `OFS_INT_ENABLE:   irq_mask <= irq_mask | hwdata[17:0];
        `OFS_INT_DISABLE:  irq_mask <= irq_mask & ~hwdata[17:0];
        default:           irq_mask <= irq_mask;
      endcase
    end
  end

  // Prescaler and conversion sequencer.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_count         <= 6'h00;
      converter_clock   <= 1'b0;
      state             <= ST_IDLE;
      phase_count       <= 5'h00;
      pending           <= 8'h00;
      channel_select    <= 3'h0;
      trig_prev         <= 1'b0;
    end else if (soft_reset) begin
      div_count       <= 6'h00;
      converter_clock <= 1'b0;
      state           <= ST_IDLE;
      pending         <= 8'h00;
      trig_prev       <= trig_level;
    end else begin
      trig_prev <= trig_level;
      // R5: divide by two times field plus one.
      if (half_tick) begin
        div_count       <= 6'h00;
        converter_clock <= ~converter_clock;
      end else begin
        div_count <= div_count + 6'h01;
      end
      case (state)
        ST_IDLE: begin
          // R18: one request covers every enabled channel.
          if (start_req && chan_enabled != 8'h00) begin
            pending <= chan_enabled;
            // R23: lowest enabled channel first.
            channel_select <= lowest_chan(chan_enabled);
            phase_count <= 5'h00;
            state <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          // R4: sample-hold clocks first.
          if (conv_edge) begin
            if (phase_count[3:0] == sample_last) begin
              phase_count <= 5'h00;
              state <= ST_CONV;
            end else begin
              phase_count <= phase_count + 5'h01;
            end
          end
        end
        ST_CONV: begin
          // R4: then ten converter clocks.
          if (conv_edge) begin
            if (phase_count[3:0] == `CONV_DATA_CLOCKS - 4'h1) begin
              phase_count <= 5'h00;
              // R23: move to next higher channel.
              if ((pending & ~(8'h01 << channel_select)) != 8'h00) begin
                pending <= pending & ~(8'h01 << channel_select);
                channel_select <= lowest_chan(pending & ~(8'h01 << channel_select));
                state <= ST_SAMPLE;
              end else begin
                pending <= 8'h00;
                state <= ST_IDLE;
              end
            end else begin
              phase_count <= phase_count + 5'h01;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // R21: starts only taken in idle, so triggers mid-sequence are dropped.
  wire conv_done = (state == ST_CONV) & conv_edge & (phase_count[3:0] == `CONV_DATA_CLOCKS - 4'h1);
  wire [9:0] shaped = shape_result(analog_result, low_resolution_select);

  // Result storage and flags; a set in the same cycle as a clear wins.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : chan_slot
      wire hit  = conv_done & (channel_select == g);
      wire rclr = (rd_chan & (rd_chan_idx == g)) | (rd_last & (last_chan == g));
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          chan_data[g] <= 10'h000;
          eoc[g]       <= 1'b0;
          overrun[g]   <= 1'b0;
        end else if (soft_reset) begin
          chan_data[g] <= 10'h000;
          eoc[g]       <= 1'b0;
          overrun[g]   <= 1'b0;
        end else begin
          // R8: store into channel register.
          if (hit) begin
            chan_data[g] <= shaped;
          end
          // R9: set end flag; R11 and R12: read clears it.
          eoc[g] <= hit | (eoc[g] & ~rclr);
          // R13: unread result overwritten; R15: status read clears.
          overrun[g] <= (hit & eoc[g] & ~rclr) | (overrun[g] & ~rd_status);
        end
      end
    end
  endgenerate

  // Last-result register, ready and general overrun flags.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_result_field    <= 10'h000;
      last_chan            <= 3'h0;
      result_ready_flag    <= 1'b0;
      general_overrun_flag <= 1'b0;
    end else if (soft_reset) begin
      last_result_field    <= 10'h000;
      last_chan            <= 3'h0;
      result_ready_flag    <= 1'b0;
      general_overrun_flag <= 1'b0;
    end else begin
      // R8: store into last-result register.
      if (conv_done) begin
        // R6: low resolution keeps upper two bits zero.
        last_result_field <= shaped;
        last_chan         <= channel_select;
      end
      // R9: ready flag set; R12: last-result read clears.
      result_ready_flag <= conv_done | (result_ready_flag & ~rd_last);
      // R14: completion with ready set; R15: status read clears.
      general_overrun_flag <= (conv_done & result_ready_flag & ~rd_last) |
                              (general_overrun_flag & ~rd_status);
    end
  end

  // Pin routing, phase outputs, interrupt and DMA request.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_to_converter <= 8'h00;
      sample_active    <= 1'b0;
      convert_active   <= 1'b0;
      converter_irq    <= 1'b0;
      dma_request      <= 1'b0;
      dma_size_16      <= 1'b1;
      ready_prev       <= 1'b0;
    end else begin
      // R17: enabled channels own their pins.
      pin_to_converter <= chan_enabled;
      // R1: a single selected input during conversion.
      sample_active    <= (state == ST_SAMPLE);
      convert_active   <= (state == ST_CONV);
      // R10: masked flags drive the interrupt.
      converter_irq    <= |(flags & irq_mask);
      // R9: ready rising issues a DMA request.
      ready_prev       <= result_ready_flag;
      dma_request      <= result_ready_flag & ~ready_prev;
      // R7: transfer width follows resolution.
      dma_size_16      <= ~low_resolution_select;
    end
  end

endmodule // sar_adc_ctrl

/* File: sar_adc_ctrl_asserts.sv */
/* Port checker for the converter control block.
   Bound to the control block; sees its ports only. */
`timescale 1ns/1ps
module sar_adc_ctrl_checker (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [2:0]  channel_select,
  input wire        sample_active,
  input wire        convert_active,
  input wire        converter_clock,
  input wire        converter_irq,
  input wire        dma_request,
  input wire        dma_size_16
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [4:0] falls;
  logic       prev_ck;
  logic       rd_take;
  // Counts converter clock falls in a convert phase and notes read phases.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      falls <= 5'h00;
      prev_ck <= 1'b0;
      rd_take <= 1'b0;
    end else begin
      prev_ck <= converter_clock;
      rd_take <= hsel && hready && htrans[1] && !hwrite;
      if (!convert_active) falls <= 5'h00;
      else if (prev_ck && !converter_clock) falls <= falls + 5'h01;
    end
  end
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  a_ready_high: assert property (hreadyout == 1'b1) else $error("wait state seen");
  a_phase_excl: assert property (!(sample_active && convert_active))
    else $error("sample and convert overlap");
  a_sample_convert: assert property ($fell(sample_active) |-> convert_active)
    else $error("convert phase did not follow sampling");
  a_conv_length: assert property ($fell(convert_active) |-> falls inside {[9:11]})
    else $error("convert phase length wrong");
  a_chan_steady: assert property ($past(sample_active) && sample_active |-> $stable(channel_select))
    else $error("channel changed while sampling");
  a_dma_pulse: assert property (dma_request |=> !dma_request)
    else $error("transfer request longer than one cycle");
  a_dma_cause: assert property ($rose(dma_request) |->
    ($past(convert_active, 1) || $past(convert_active, 2) || $past(convert_active, 3) || $past(convert_active, 4)))
    else $error("transfer request without conversion");
  a_rdata_hold: assert property (!rd_take |-> $stable(hrdata)) else $error("read data moved");
  c_dma: cover property (dma_request);
  c_start: cover property ($rose(sample_active));
  c_low_res: cover property (dma_request && !dma_size_16);
  c_irq: cover property (converter_irq);
endmodule // sar_adc_ctrl_checker
